//--- xpt_board.sv
// board end: stream decode, chip loading, and the link's selection fifo
`timescale 1ns/1ps
module xpt_board
#(
   parameter int LANE = 0
)
(
   // system clock and reset
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   // link from the combiner
   xpt_link_if.board link,
   // crosspoint chip side, link clock domain
   output logic crosspoint_load_pulse_o,
   output logic xpt_bit_line_first_o,
   output logic xpt_bit_line_second_o,
   output logic xpt_bit_line_third_o,
   output logic xpt_chip_reset_o,
   output logic activity_o,
   output logic [1:0] board_position_o
);
   import xpt_ctrl_pkg::*;

   typedef struct packed
   {
      load_state_type state;
      logic [1:0] pos;
      logic [FRAME_BITS-1:0] shadow;
      logic [CHIPS_PER_BOARD-1:0][XPT_LOAD_BITS-1:0] load;
      logic [6:0] cnt;
      logic pulse;
      logic [CHIPS_PER_BOARD-1:0] dline;
      logic [4:0] rst_cnt;
      logic act;
   } board_state_type;

   board_state_type st_r, st_nxt;
   logic rst_q_r;
   logic [2:0] rst_hold_r;
   logic [1:0] rst_sync_r;
   logic link_rst;
   logic [LOCAL_W:0] loc;

   initial
   begin
      if (LANE < 0 || LANE >= NUM_BOARDS)
         $error("lane must select one of the fanned-out boards");
   end

   // stretch reset so that the slower link clock surely samples it
   always_ff @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
      begin
         rst_hold_r <= RST_STRETCH;
         rst_q_r <= 1'b1;
      end
      else
      begin
         if (rst_hold_r != 3'h0)
            rst_hold_r <= rst_hold_r - 1'b1;
         rst_q_r <= (rst_hold_r != 3'h0);
      end
   end

   always_ff @(posedge link.link_clk)
   begin
      rst_sync_r <= {rst_sync_r[0], rst_q_r};
   end
   assign link_rst = rst_sync_r[1];

   always_comb
   begin
      st_nxt = st_r;
      loc = '0;
      st_nxt.pulse = 1'b0;
      st_nxt.pos = {link.slot_position_bit_hi[LANE],
                    link.slot_position_bit_lo[LANE]};
      if (st_r.rst_cnt != '0)
         st_nxt.rst_cnt = st_r.rst_cnt - 1'b1;
      if (link.xpt_board_stream_frame[LANE] &&
          link.xpt_board_stream_shift[LANE])
         st_nxt.shadow = {st_r.shadow[FRAME_BITS-2:0],
                          link.xpt_board_stream_bits[LANE]};
      unique case (st_r.state)
         LD_IDLE:
         begin
            st_nxt.dline = '0;
         end
         LD_DRIVE:
         begin
            for (int c = 0; c < CHIPS_PER_BOARD; c++)
               st_nxt.dline[c] = st_r.load[c][XPT_LOAD_BITS-1];
            st_nxt.state = LD_PULSE;
         end
         LD_PULSE:
         begin
            st_nxt.pulse = 1'b1;
            for (int c = 0; c < CHIPS_PER_BOARD; c++)
               st_nxt.load[c] = {st_r.load[c][XPT_LOAD_BITS-2:0], 1'b0};
            st_nxt.cnt = st_r.cnt + 1'b1;
            st_nxt.state = (st_r.cnt == LAST_LOAD_BIT) ? LD_IDLE : LD_DRIVE;
         end
      endcase
      if (link.xpt_board_switch_trigger[LANE] && st_r.rst_cnt == '0)
      begin
         st_nxt.cnt = '0;
         st_nxt.state = LD_DRIVE;
         for (int j = 0; j < NUM_OUTPUTS; j++)
         begin
            loc = local_input(field_of(st_r.shadow, j), st_r.pos);
            for (int c = 0; c < CHIPS_PER_BOARD; c++)
            begin
               st_nxt.load[c][XPT_LOAD_BITS - 1 - j * XPT_WORD_W -:
                              XPT_WORD_W] =
                  (loc[LOCAL_W] && int'(loc[LOCAL_W-1:0]) / CHIP_INPUTS == c)
                  ? {1'b1, loc[CHIP_SEL_W-1:0]} : '0;
            end
         end
      end
      st_nxt.act = link.xpt_board_stream_frame[LANE] ||
                   (st_nxt.state != LD_IDLE);
   end

   always_ff @(posedge link.link_clk)
   begin
      if (link_rst)
      begin
         st_r <= '0;
         st_r.rst_cnt <= XPT_RESET_CYCLES;
      end
      else
         st_r <= st_nxt;
   end

   assign crosspoint_load_pulse_o = st_r.pulse;
   assign xpt_bit_line_first_o = st_r.dline[0];
   assign xpt_bit_line_second_o = st_r.dline[1];
   assign xpt_bit_line_third_o = st_r.dline[2];
   assign xpt_chip_reset_o = (st_r.rst_cnt != '0) || link_rst;
   assign activity_o = st_r.act;
   assign board_position_o = st_r.pos;
endmodule : xpt_board

module sel_fifo
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
)
(
   // write side
   input wire logic wr_clk_i,
   input wire logic wr_rst_i,
   input wire logic wr_valid_i,
   output logic wr_ready_o,
   input wire logic [WIDTH-1:0] wr_data_i,
   // read side
   input wire logic rd_clk_i,
   input wire logic rd_rst_i,
   output logic rd_valid_o,
   input wire logic rd_ready_i,
   output logic [WIDTH-1:0] rd_data_o
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed
   {
      logic [AW:0] bin;
      logic [AW:0] gray;
      logic [AW:0] far_s1;
      logic [AW:0] far_s2;
   } ptr_state_type;

   ptr_state_type wr_r, wr_nxt, rd_r, rd_nxt;
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW:0] far_full;

   initial
   begin
      if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
         $error("fifo depth must be a power of two, at least 2");
   end

   function automatic logic [AW:0] to_gray(input logic [AW:0] b);
      return b ^ (b >> 1);
   endfunction : to_gray

   assign far_full = {~wr_r.far_s2[AW:AW-1], wr_r.far_s2[AW-2:0]};
   // refuse words while the write side is held in reset
   assign wr_ready_o = !wr_rst_i && (wr_r.gray != far_full);
   assign rd_valid_o = (rd_r.gray != rd_r.far_s2);
   assign rd_data_o = mem_r[rd_r.bin[AW-1:0]];

   always_comb
   begin
      wr_nxt = wr_r;
      wr_nxt.far_s1 = rd_r.gray;
      wr_nxt.far_s2 = wr_r.far_s1;
      if (wr_valid_i && wr_ready_o)
      begin
         wr_nxt.bin = wr_r.bin + 1'b1;
         wr_nxt.gray = to_gray(wr_nxt.bin);
      end
      rd_nxt = rd_r;
      rd_nxt.far_s1 = wr_r.gray;
      rd_nxt.far_s2 = rd_r.far_s1;
      if (rd_valid_o && rd_ready_i)
      begin
         rd_nxt.bin = rd_r.bin + 1'b1;
         rd_nxt.gray = to_gray(rd_nxt.bin);
      end
   end

   always_ff @(posedge wr_clk_i)
   begin
      if (wr_rst_i)
         wr_r <= '0;
      else
         wr_r <= wr_nxt;
      if (wr_valid_i && wr_ready_o)
         mem_r[wr_r.bin[AW-1:0]] <= wr_data_i;
   end

   always_ff @(posedge rd_clk_i)
   begin
      if (rd_rst_i)
         rd_r <= '0;
      else
         rd_r <= rd_nxt;
   end
endmodule : sel_fifo

//--- xpt_ctrl_pkg.sv
// shared constants, types and decoders for the crosspoint control link
package xpt_ctrl_pkg;
   localparam int NUM_OUTPUTS = 16;
   localparam int SEL_W = 8;
   localparam int NUM_BOARDS = 3;
   localparam int BOARD_INPUTS = 48;
   localparam int CHIP_INPUTS = 16;
   localparam int CHIPS_PER_BOARD = 3;
   localparam int CHIP_SEL_W = 4;
   localparam int XPT_WORD_W = CHIP_SEL_W + 1;
   localparam int XPT_LOAD_BITS = NUM_OUTPUTS * XPT_WORD_W;
   localparam int FRAME_BITS = NUM_OUTPUTS * SEL_W;
   localparam int LOCAL_W = 6;
   localparam logic [4:0] XPT_RESET_CYCLES = 5'h10;
   localparam logic [2:0] RST_STRETCH = 3'h7;
   localparam logic [1:0] SRC_GROUND = 2'h3;
   localparam logic [2:0] LAST_BIT = 3'h7;
   localparam logic [3:0] LAST_WORD = 4'hF;
   localparam logic [6:0] LAST_LOAD_BIT = 7'h4F;

   typedef enum logic [1:0]
   {
      TX_IDLE = 2'h0,
      TX_POP = 2'h1,
      TX_SETUP = 2'h3,
      TX_SHIFT = 2'h2
   } tx_state_type;

   typedef enum logic [1:0]
   {
      LD_IDLE = 2'h0,
      LD_DRIVE = 2'h1,
      LD_PULSE = 2'h3
   } load_state_type;

   // which board serves an input number; zero or out of range is ground
   function automatic logic [1:0] source_of(input logic [SEL_W-1:0] n);
      int v;
      v = int'(n);
      if (v == 0 || v > NUM_BOARDS * BOARD_INPUTS)
         return SRC_GROUND;
      return 2'((v - 1) / BOARD_INPUTS);
   endfunction : source_of

   // board-local input index with a valid flag on top
   function automatic logic [LOCAL_W:0] local_input(
      input logic [SEL_W-1:0] n, input logic [1:0] pos);
      int v;
      v = int'(n) - 1 - int'(pos) * BOARD_INPUTS;
      if (v < 0 || v >= BOARD_INPUTS)
         return '0;
      return {1'b1, LOCAL_W'(v)};
   endfunction : local_input

   // selection field of one output inside the frame, output 0 sent first
   function automatic logic [SEL_W-1:0] field_of(
      input logic [FRAME_BITS-1:0] f, input int j);
      return f[FRAME_BITS - 1 - j * SEL_W -: SEL_W];
   endfunction : field_of
endpackage : xpt_ctrl_pkg

//--- xpt_link_if.sv
// link between the combiner and its three crosspoint boards
`timescale 1ns/1ps
interface xpt_link_if
(
   input wire logic link_clk
);
   logic [xpt_ctrl_pkg::NUM_BOARDS-1:0] xpt_board_stream_bits;
   logic [xpt_ctrl_pkg::NUM_BOARDS-1:0] xpt_board_stream_shift;
   logic [xpt_ctrl_pkg::NUM_BOARDS-1:0] xpt_board_stream_frame;
   logic [xpt_ctrl_pkg::NUM_BOARDS-1:0] xpt_board_switch_trigger;
   logic [xpt_ctrl_pkg::NUM_BOARDS-1:0] slot_position_bit_lo;
   logic [xpt_ctrl_pkg::NUM_BOARDS-1:0] slot_position_bit_hi;

   modport combiner
   (
      input link_clk,
      output xpt_board_stream_bits,
      output xpt_board_stream_shift,
      output xpt_board_stream_frame,
      output xpt_board_switch_trigger,
      output slot_position_bit_lo,
      output slot_position_bit_hi
   );

   modport board
   (
      input link_clk,
      input xpt_board_stream_bits,
      input xpt_board_stream_shift,
      input xpt_board_stream_frame,
      input xpt_board_switch_trigger,
      input slot_position_bit_lo,
      input slot_position_bit_hi
   );
endinterface : xpt_link_if

//--- xpt_combiner.sv
// combiner end: selection fifo, stream serializer and combiner selects
`timescale 1ns/1ps
module xpt_combiner
#(
   parameter int FIFO_DEPTH = 4
)
(
   // system clock and reset
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   // selection words from the controller, output 0 first
   input wire logic sel_valid_i,
   output logic sel_ready_o,
   input wire logic [xpt_ctrl_pkg::SEL_W-1:0] sel_data_i,
   input wire logic field_switch_trigger_i,
   // link to the crosspoint boards
   xpt_link_if.combiner link,
   // combiner selects, link clock domain
   output logic [xpt_ctrl_pkg::NUM_OUTPUTS-1:0] combiner_select_low_o,
   output logic [xpt_ctrl_pkg::NUM_OUTPUTS-1:0] combiner_select_high_o,
   output logic frame_busy_o
);
   import xpt_ctrl_pkg::*;

   typedef struct packed
   {
      logic rst_q;
      logic [2:0] rst_hold;
      logic trig_tgl;
   } ref_state_type;

   typedef struct packed
   {
      tx_state_type state;
      logic [SEL_W-1:0] word;
      logic [2:0] bit_cnt;
      logic [3:0] word_cnt;
      logic [FRAME_BITS-1:0] shadow;
      logic [NUM_OUTPUTS-1:0] sel_lo;
      logic [NUM_OUTPUTS-1:0] sel_hi;
      logic bits;
      logic shift;
      logic frame;
      logic trig;
      logic [2:0] trig_sync;
   } link_state_type;

   ref_state_type ref_r, ref_nxt;
   link_state_type lnk_r, lnk_nxt;
   logic [1:0] rst_sync_r;
   logic link_rst;
   logic fifo_valid;
   logic [SEL_W-1:0] fifo_data;
   logic pop;

   initial
   begin
      if (FIFO_DEPTH != 4)
         $error("selection fifo depth is fixed at 4 words");
   end

   sel_fifo #(.WIDTH(SEL_W), .DEPTH(FIFO_DEPTH)) u_fifo
   (
      .wr_clk_i(ref_clk_i),
      .wr_rst_i(ref_r.rst_q),
      .wr_valid_i(sel_valid_i),
      .wr_ready_o(sel_ready_o),
      .wr_data_i(sel_data_i),
      .rd_clk_i(link.link_clk),
      .rd_rst_i(link_rst),
      .rd_valid_o(fifo_valid),
      .rd_ready_i(pop),
      .rd_data_o(fifo_data)
   );

   always_comb
   begin
      ref_nxt = ref_r;
      // keep reset up long enough for the slower link clock to see it
      ref_nxt.rst_q = (ref_r.rst_hold != 3'h0);
      if (ref_r.rst_hold != 3'h0)
         ref_nxt.rst_hold = ref_r.rst_hold - 1'b1;
      if (field_switch_trigger_i)
         ref_nxt.trig_tgl = ~ref_r.trig_tgl;
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
         ref_r <= '{rst_q: 1'b1, rst_hold: RST_STRETCH, trig_tgl: 1'b0};
      else
         ref_r <= ref_nxt;
   end

   always_ff @(posedge link.link_clk)
   begin
      rst_sync_r <= {rst_sync_r[0], ref_r.rst_q};
   end
   assign link_rst = rst_sync_r[1];

   assign pop = (lnk_r.state == TX_POP) && fifo_valid;

   always_comb
   begin
      lnk_nxt = lnk_r;
      lnk_nxt.shift = 1'b0;
      lnk_nxt.trig = 1'b0;
      lnk_nxt.trig_sync = {lnk_r.trig_sync[1:0], ref_r.trig_tgl};
      if (lnk_r.trig_sync[2] != lnk_r.trig_sync[1])
      begin
         lnk_nxt.trig = 1'b1;
         for (int j = 0; j < NUM_OUTPUTS; j++)
         begin
            {lnk_nxt.sel_hi[j], lnk_nxt.sel_lo[j]} =
               source_of(field_of(lnk_r.shadow, j));
         end
      end
      unique case (lnk_r.state)
         TX_IDLE:
         begin
            lnk_nxt.word_cnt = '0;
            lnk_nxt.frame = 1'b0;
            if (fifo_valid)
               lnk_nxt.state = TX_POP;
         end
         TX_POP:
         begin
            lnk_nxt.frame = 1'b1;
            if (fifo_valid)
            begin
               lnk_nxt.word = fifo_data;
               lnk_nxt.bit_cnt = '0;
               lnk_nxt.state = TX_SETUP;
            end
         end
         TX_SETUP:
         begin
            lnk_nxt.bits = lnk_r.word[SEL_W-1];
            lnk_nxt.state = TX_SHIFT;
         end
         TX_SHIFT:
         begin
            lnk_nxt.shift = 1'b1;
            lnk_nxt.shadow = {lnk_r.shadow[FRAME_BITS-2:0], lnk_r.bits};
            lnk_nxt.word = {lnk_r.word[SEL_W-2:0], 1'b0};
            lnk_nxt.bit_cnt = lnk_r.bit_cnt + 1'b1;
            lnk_nxt.state = TX_SETUP;
            if (lnk_r.bit_cnt == LAST_BIT)
            begin
               lnk_nxt.word_cnt = lnk_r.word_cnt + 1'b1;
               lnk_nxt.state = TX_POP;
               if (lnk_r.word_cnt == LAST_WORD)
               begin
                  lnk_nxt.state = TX_IDLE;
               end
            end
         end
      endcase
   end

   always_ff @(posedge link.link_clk)
   begin
      if (link_rst)
      begin
         lnk_r <= '0;
         lnk_r.sel_lo <= '1;
         lnk_r.sel_hi <= '1;
      end
      else
         lnk_r <= lnk_nxt;
   end

   genvar b;
   generate
      for (b = 0; b < NUM_BOARDS; b++)
      begin : g_fan
         assign link.xpt_board_stream_bits[b] = lnk_r.bits;
         assign link.xpt_board_stream_shift[b] = lnk_r.shift;
         assign link.xpt_board_stream_frame[b] = lnk_r.frame;
         assign link.xpt_board_switch_trigger[b] = lnk_r.trig;
         assign link.slot_position_bit_lo[b] = 1'(b & 1);
         assign link.slot_position_bit_hi[b] = 1'((b >> 1) & 1);
      end
   endgenerate

   assign combiner_select_low_o = lnk_r.sel_lo;
   assign combiner_select_high_o = lnk_r.sel_hi;
   assign frame_busy_o = lnk_r.frame;
endmodule : xpt_combiner

//--- xpt_link_asserts.sv
// concurrent checks on the combiner to board link
`timescale 1ns/1ps
module xpt_link_asserts
import xpt_ctrl_pkg::*;
(
   // link clock and reset
   input wire logic link_clk,
   input wire logic sys_rst_i,
   // link lanes
   input wire logic [NUM_BOARDS-1:0] xpt_board_stream_bits,
   input wire logic [NUM_BOARDS-1:0] xpt_board_stream_shift,
   input wire logic [NUM_BOARDS-1:0] xpt_board_stream_frame,
   input wire logic [NUM_BOARDS-1:0] xpt_board_switch_trigger,
   input wire logic [NUM_BOARDS-1:0] slot_position_bit_lo,
   input wire logic [NUM_BOARDS-1:0] slot_position_bit_hi
);
   logic frame_r;
   logic [7:0] shift_cnt_r;
   logic [2:0] settle_r;
   logic link_quiet;

   // link logic leaves reset some link cycles after the system reset
   always_ff @(posedge link_clk)
   begin
      if (sys_rst_i)
         settle_r <= 3'h7;
      else if (settle_r != 3'h0)
         settle_r <= settle_r - 3'h1;
   end
   assign link_quiet = sys_rst_i || (settle_r != 3'h0);

   // shifts seen since the frame line last rose
   always_ff @(posedge link_clk)
   begin
      if (sys_rst_i)
      begin
         frame_r <= 1'b0;
         shift_cnt_r <= 8'h00;
      end
      else
      begin
         frame_r <= xpt_board_stream_frame[0];
         if (xpt_board_stream_frame[0] && !frame_r)
            shift_cnt_r <= 8'h00;
         else if (xpt_board_stream_shift[0])
            shift_cnt_r <= shift_cnt_r + 8'h01;
      end
   end

   default clocking cb @(posedge link_clk); endclocking
   default disable iff (link_quiet);

   sequence frame_open_s;
      $rose(xpt_board_stream_frame[0]);
   endsequence

   sequence first_bit_s;
      ##[1:4] xpt_board_stream_shift[0];
   endsequence

   a_shift_in_frame: assert property (
      |xpt_board_stream_shift |-> xpt_board_stream_frame == 3'h7)
      else $error("shift outside frame");
   a_shift_single_pulse: assert property (
      xpt_board_stream_shift[0] |=> !xpt_board_stream_shift[0])
      else $error("shift pulse too long");
   a_bits_held_stable: assert property (
      xpt_board_stream_shift[0] |-> $stable(xpt_board_stream_bits))
      else $error("data changed on shift");
   a_slot_codes_fixed: assert property (
      slot_position_bit_lo == 3'h2 && slot_position_bit_hi == 3'h4)
      else $error("slot codes wrong");
   a_lanes_fanned_out: assert property (
      xpt_board_stream_shift == {3{xpt_board_stream_shift[0]}} &&
      xpt_board_stream_bits == {3{xpt_board_stream_bits[0]}} &&
      xpt_board_switch_trigger == {3{xpt_board_switch_trigger[0]}})
      else $error("lanes differ");
   a_trigger_single_pulse: assert property (
      xpt_board_switch_trigger[0] |=> !xpt_board_switch_trigger[0])
      else $error("trigger pulse too long");
   a_frame_bit_count: assert property (
      $fell(xpt_board_stream_frame[0]) |-> shift_cnt_r == 8'h80)
      else $error("frame length wrong");
   a_frame_starts_soon: assert property (
      frame_open_s |-> first_bit_s)
      else $error("no bit after frame start");
   cover property (xpt_board_switch_trigger[0]);
endmodule : xpt_link_asserts

//--- testbench.sv
// self-checking bench for combiner and three boards
`timescale 1ns/1ps
`define CHK(a, b, m) begin num_checks++; if ((a) !== (b)) begin failures++; \
   $display("MISMATCH %0t %s", $time, m); end end
module testbench;
   import xpt_ctrl_pkg::*;
   typedef struct packed {logic [SEL_W-1:0] n; logic [1:0] code;} row_type;
   localparam row_type ROWS [NUM_OUTPUTS] = '{
      '{8'h01, 2'h0}, '{8'h00, 2'h3}, '{8'h30, 2'h0}, '{8'h31, 2'h1},
      '{8'h60, 2'h1}, '{8'h61, 2'h2}, '{8'h90, 2'h2}, '{8'h91, 2'h3},
      '{8'hFF, 2'h3}, '{8'h14, 2'h0}, '{8'h3C, 2'h1}, '{8'h64, 2'h2},
      '{8'h21, 2'h0}, '{8'h11, 2'h0}, '{8'h82, 2'h2}, '{8'h05, 2'h0}};
   logic ref_clk_i = 1'b0;
   logic link_clk = 1'b0;
   logic sys_rst_i = 1'b1;
   logic sel_valid_i = 1'b0;
   logic field_switch_trigger_i = 1'b0;
   logic [SEL_W-1:0] sel_data_i = 8'h00;
   logic sel_ready_o;
   logic frame_busy_o;
   logic rdy_q;
   logic [NUM_OUTPUTS-1:0] sel_lo, sel_hi, elo, ehi;
   logic [2:0] ld_pulse, line1, line2, line3, chip_rst, act;
   logic [1:0] pos [3];
   logic [FRAME_BITS-1:0] cap, expf;
   logic [XPT_LOAD_BITS-1:0] ld, ld2, ld3;
   int failures = 0, num_checks = 0, cycles = 0;
   int ncap = 0, nld = 0, refused = 0;

   initial forever #2 ref_clk_i = ~ref_clk_i;
   initial
   begin
      #1.3;
      forever #6 link_clk = ~link_clk;
   end

   xpt_link_if xpt_link_if_inst(.link_clk(link_clk));
   xpt_combiner #(.FIFO_DEPTH(4)) xpt_combiner_inst(.ref_clk_i(ref_clk_i),
      .sys_rst_i(sys_rst_i), .sel_valid_i(sel_valid_i),
      .sel_ready_o(sel_ready_o), .sel_data_i(sel_data_i),
      .field_switch_trigger_i(field_switch_trigger_i),
      .link(xpt_link_if_inst), .combiner_select_low_o(sel_lo),
      .combiner_select_high_o(sel_hi), .frame_busy_o(frame_busy_o));
   for (genvar g = 0; g < 3; g++)
   begin : lanes
      xpt_board #(.LANE(g)) xpt_board_inst(.ref_clk_i(ref_clk_i),
         .sys_rst_i(sys_rst_i), .link(xpt_link_if_inst),
         .crosspoint_load_pulse_o(ld_pulse[g]),
         .xpt_bit_line_first_o(line1[g]), .xpt_bit_line_second_o(line2[g]),
         .xpt_bit_line_third_o(line3[g]), .xpt_chip_reset_o(chip_rst[g]),
         .activity_o(act[g]), .board_position_o(pos[g]));
   end
   xpt_link_asserts xpt_link_asserts_inst(.link_clk(link_clk),
      .sys_rst_i(sys_rst_i),
      .xpt_board_stream_bits(xpt_link_if_inst.xpt_board_stream_bits),
      .xpt_board_stream_shift(xpt_link_if_inst.xpt_board_stream_shift),
      .xpt_board_stream_frame(xpt_link_if_inst.xpt_board_stream_frame),
      .xpt_board_switch_trigger(xpt_link_if_inst.xpt_board_switch_trigger),
      .slot_position_bit_lo(xpt_link_if_inst.slot_position_bit_lo),
      .slot_position_bit_hi(xpt_link_if_inst.slot_position_bit_hi));

   task results;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : results

   // holds the word until the edge that takes it
   task send(input logic [SEL_W-1:0] n);
      sel_valid_i = 1'b1;
      sel_data_i = n;
      do
      begin
         @(negedge ref_clk_i);
         if (rdy_q !== 1'b1)
            refused++;
      end while (rdy_q !== 1'b1);
   endtask : send

   always @(posedge ref_clk_i)
   begin
      rdy_q <= sel_ready_o;
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         failures++;
         results();
      end
   end

   // wire capture of lane 0 and chip line loading of board 0
   always @(posedge link_clk)
   begin
      if (xpt_link_if_inst.xpt_board_stream_frame[0] &&
         xpt_link_if_inst.xpt_board_stream_shift[0])
      begin
         cap <= {cap[FRAME_BITS-2:0], xpt_link_if_inst.xpt_board_stream_bits[0]};
         ncap <= ncap + 1;
      end
      if (ld_pulse[0])
      begin
         ld <= {ld[XPT_LOAD_BITS-2:0], line1[0]};
         ld2 <= {ld2[XPT_LOAD_BITS-2:0], line2[0]};
         ld3 <= {ld3[XPT_LOAD_BITS-2:0], line3[0]};
         nld <= nld + 1;
      end
   end

   initial
   begin
      repeat (3) @(negedge ref_clk_i);
      `CHK(sel_ready_o, 1'b0, "ready held in reset")
      sys_rst_i = 1'b0;
      repeat (12) @(negedge ref_clk_i);
      `CHK(chip_rst, 3'h7, "chip reset held")
      `CHK(sel_lo & sel_hi, 16'hFFFF, "reset selects")
      repeat (120) @(negedge ref_clk_i);
      `CHK(chip_rst, 3'h0, "chip reset released")
      for (int b = 0; b < 3; b++)
         `CHK(pos[b], 2'(b), "board position")
      for (int j = 0; j < NUM_OUTPUTS; j++)
      begin
         expf = {expf[FRAME_BITS-SEL_W-1:0], ROWS[j].n};
         elo[j] = ROWS[j].code[0];
         ehi[j] = ROWS[j].code[1];
      end
      for (int j = 0; j < NUM_OUTPUTS; j++)
         send(ROWS[j].n);
      sel_valid_i = 1'b0;
      `CHK(refused > 0, 1'b1, "fifo never refused")
      `CHK(act[0], 1'b1, "activity during frame")
      for (int k = 0; k < 4000 && frame_busy_o !== 1'b0; k++)
         @(negedge ref_clk_i);
      `CHK(frame_busy_o, 1'b0, "frame never ended")
      `CHK(ncap, FRAME_BITS, "bits per frame")
      `CHK(cap, expf, "frame bit order")
      repeat (30) @(negedge ref_clk_i);
      `CHK(sel_lo & sel_hi, 16'hFFFF, "selects moved early")
      field_switch_trigger_i = 1'b1;
      @(negedge ref_clk_i);
      field_switch_trigger_i = 1'b0;
      repeat (40) @(negedge ref_clk_i);
      `CHK(sel_lo, elo, "low selects")
      `CHK(sel_hi, ehi, "high selects")
      repeat (600) @(negedge ref_clk_i);
      `CHK(nld, XPT_LOAD_BITS, "load pulses")
      `CHK(ld[XPT_LOAD_BITS-1 -: XPT_WORD_W], 5'h10, "chip word")
      // output 9 picks input 20, output 2 picks input 48
      `CHK(ld2[34 -: 5], 5'h13, "second chip word")
      `CHK(ld3[69 -: 5], 5'h1F, "third chip word")
      `CHK(act, 3'h0, "activity after load")
      results();
   end
endmodule : testbench
